// ==== pll_ctl_pkg.sv ====
package pll_ctl_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] ctrl_addr = 12'h000;
  localparam logic [11:0] stat_addr = 12'h004;
  localparam logic [11:0] lock_addr = 12'h008;
  localparam logic [11:0] cnt_addr = 12'h00c;
  localparam logic [31:0] ctrl_reset = 32'h0000_0011;
  localparam logic [31:0] lock_reset = 32'h0000_0010;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int ctrl_code_lo = 0;
  localparam int ctrl_acq_en_bit = 4;
  localparam int ctrl_fifo_en_bit = 5;
  // ****************************************
  // Code types and divisors
  // ****************************************
  localparam logic [2:0] code_gcr = 3'h0;
  localparam logic [2:0] code_mfm = 3'h1;
  localparam logic [2:0] code_17 = 3'h2;
  localparam logic [2:0] code_18 = 3'h3;
  localparam logic [2:0] code_27h = 3'h4;
  localparam logic [2:0] code_27l = 3'h5;
  localparam logic [2:0] div_one = 3'h1;
  localparam logic [2:0] div_two = 3'h2;
  localparam logic [2:0] div_three = 3'h3;
  localparam logic [2:0] div_four = 3'h4;
  // ****************************************
  // Timing
  // ****************************************
  localparam int sys_clk_mhz = 50;
  localparam int half_period_ns = 100;
  localparam int half_period_cyc_raw =
      (half_period_ns * sys_clk_mhz + 999) / 1000;
  localparam int half_period_cyc =
      (half_period_cyc_raw < 1) ? 1 : half_period_cyc_raw;
  localparam int fifo_width = 8;
  localparam int fifo_depth = 8;
  typedef enum logic [1:0] {
    mode_ref = 2'b00,
    mode_acq = 2'b01,
    mode_gate = 2'b11,
    mode_spare = 2'b10
  } mode_t;
endpackage : pll_ctl_pkg

// ==== pll_fifo.sv ====
`timescale 1ns/1ps
module pll_fifo #(
  parameter int width = 8,
  parameter int depth = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0] wr_q;
  logic [aw-1:0] rd_q;
  logic [aw:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != depth[aw:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == aw'(depth - 1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == aw'(depth - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + {aw'(0), push} - {aw'(0), pop};
    end
  end
endmodule : pll_fifo

// ==== pll_delay.sv ====
`timescale 1ns/1ps
module pll_delay #(
  parameter int taps = 5
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic step_en,
  input wire logic din,
  output logic dout
);
  // Shifting only on the reference-derived step keeps the delay tied to
  // that clock rather than to the fast system clock.
  logic [taps-1:0] line_q;
  assign dout = line_q[taps-1];
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      line_q <= '0;
    end else if (step_en) begin
      line_q <= {line_q[taps-2:0], din};
    end else if (din) begin
      line_q[0] <= 1'b1;
    end
  end
endmodule : pll_delay

// ==== pll_phase_ctl.sv ====
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// How it works
// - Phase is judged only from rising edges of reference and oscillator.
// - Latch pair: up when reference leads, down when it lags.
// - Up gates sourcing current, down gates sinking current while held.
// - Ungated comparison acts as frequency discriminator toward reference.
// - A data bit opens the gate for exactly the next oscillator edge.
// - No data bit means closed gate, no comparison, no pump output.
// - Data opens gate at once, reaches detector half a period later.
// - Bits up to half a cycle off still meet the correct edge.
// - Data delay is stepped from the double-rate reference clock.
// - Frequency lock bypasses the pulse gate internally.
// - Non-read mode tracks the reference with the gate bypassed.
// - Preamble acquisition divides the oscillator by the code's divisor.
// - Detected frequency lock returns to gated mode before data.
module pll_phase_ctl (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic double_rate_reference_clock,
  input wire logic oscillator_frequency,
  input wire logic read_data,
  input wire logic read_gate,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pump_up,
  output logic pump_down,
  output logic acq_mode,
  output logic gated_mode,
  output logic [7:0] win_data,
  output logic win_valid,
  input wire logic win_ready
);
  // ****************************************
  // Edge detection
  // ****************************************
  logic ref_q;
  logic osc_q;
  logic dat_q;
  logic rg_q;
  logic ref_half_q;
  wire ref_rise = double_rate_reference_clock && !ref_q;
  wire osc_rise = oscillator_frequency && !osc_q;
  wire dat_rise = read_data && !dat_q;
  wire rg_rise = read_gate && !rg_q;
  wire rg_fall = !read_gate && rg_q;
  // The reference runs at twice the bit rate, so every second edge is one
  // reference cycle and each edge marks half an oscillator period.
  wire ref_cycle = ref_rise && ref_half_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ref_q <= 1'b0;
      osc_q <= 1'b0;
      dat_q <= 1'b0;
      rg_q <= 1'b0;
      ref_half_q <= 1'b0;
    end else begin
      ref_q <= double_rate_reference_clock;
      osc_q <= oscillator_frequency;
      dat_q <= read_data;
      rg_q <= read_gate;
      if (ref_rise) ref_half_q <= !ref_half_q;
    end
  end
  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl_q;
  logic [31:0] lock_q;
  logic [31:0] cmp_cnt_q;
  logic [31:0] rdata_d;
  logic [31:0] stat_w;
  pll_ctl_pkg::mode_t mode_q;
  pll_ctl_pkg::mode_t mode_d;
  logic locked_q;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = (paddr == pll_ctl_pkg::ctrl_addr);
  wire hit_stat = (paddr == pll_ctl_pkg::stat_addr);
  wire hit_lock = (paddr == pll_ctl_pkg::lock_addr);
  wire hit_cnt = (paddr == pll_ctl_pkg::cnt_addr);
  wire hit_any = hit_ctrl || hit_stat || hit_lock || hit_cnt;
  wire [2:0] code_sel = ctrl_q[pll_ctl_pkg::ctrl_code_lo +: 3];
  wire acq_en = ctrl_q[pll_ctl_pkg::ctrl_acq_en_bit];
  wire fifo_en = ctrl_q[pll_ctl_pkg::ctrl_fifo_en_bit];
  assign stat_w = {24'h0, 2'h0, locked_q, pump_down, pump_up,
                   read_gate, mode_q};
  assign rdata_d = hit_ctrl ? ctrl_q :
                   hit_stat ? stat_w :
                   hit_lock ? lock_q :
                   hit_cnt ? cmp_cnt_q : 32'h0;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= pll_ctl_pkg::ctrl_reset;
      lock_q <= pll_ctl_pkg::lock_reset;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !pready && penable;
      pslverr <= acc && !pready && !hit_any;
      if (acc && !pready) prdata <= rdata_d;
      // Writes land on the edge where the master samples pready high.
      if (wr && pready && hit_ctrl) ctrl_q <= pwdata;
      if (wr && pready && hit_lock) lock_q <= pwdata;
    end
  end
  // ****************************************
  // Mode control
  // ****************************************
  logic [2:0] divisor;
  always_comb begin
    case (code_sel)
      pll_ctl_pkg::code_gcr: divisor = pll_ctl_pkg::div_one;
      pll_ctl_pkg::code_mfm: divisor = pll_ctl_pkg::div_two;
      pll_ctl_pkg::code_17: divisor = pll_ctl_pkg::div_two;
      pll_ctl_pkg::code_18: divisor = pll_ctl_pkg::div_two;
      pll_ctl_pkg::code_27h: divisor = pll_ctl_pkg::div_three;
      pll_ctl_pkg::code_27l: divisor = pll_ctl_pkg::div_four;
      default: divisor = pll_ctl_pkg::div_two;
    endcase
  end
  // Acquisition trusts the controller to raise read gate at preamble
  // start; starting inside random data would mislock the loop.
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      pll_ctl_pkg::mode_ref: begin
        if (rg_rise) begin
          mode_d = acq_en ? pll_ctl_pkg::mode_acq : pll_ctl_pkg::mode_gate;
        end
      end
      pll_ctl_pkg::mode_acq: begin
        if (rg_fall) mode_d = pll_ctl_pkg::mode_ref;
        else if (locked_q) mode_d = pll_ctl_pkg::mode_gate;
      end
      pll_ctl_pkg::mode_gate: begin
        if (rg_fall) mode_d = pll_ctl_pkg::mode_ref;
      end
      default: mode_d = pll_ctl_pkg::mode_ref;
    endcase
  end
  wire mode_chg = (mode_d != mode_q);
  // ****************************************
  // Divider, delay and pulse gate
  // ****************************************
  logic [2:0] div_cnt_q;
  logic gate_q;
  logic dly_out;
  wire div_wrap = (div_cnt_q == divisor - 3'h1);
  wire osc_div = osc_rise && div_wrap;
  pll_delay #(.taps(2)) u_delay (
    .sys_clk(sys_clk),
    .srst(srst),
    .step_en(ref_rise),
    .din(dat_rise),
    .dout(dly_out)
  );
  logic dly_q;
  wire dly_rise = dly_out && !dly_q;
  wire is_ref = (mode_q == pll_ctl_pkg::mode_ref);
  wire is_acq = (mode_q == pll_ctl_pkg::mode_acq);
  wire is_gate = (mode_q == pll_ctl_pkg::mode_gate);
  // Reference input: reference cycles, raw data, or delayed data.
  wire cmp_ref = is_ref ? ref_cycle : (is_acq ? dat_rise : dly_rise);
  // Oscillator input: bypassed, divided, or passed by the pulse gate.
  wire cmp_osc = is_ref ? osc_rise :
                 is_acq ? osc_div :
                 (osc_rise && (gate_q || dat_rise));
  always_ff @(posedge sys_clk) begin
    if (srst || mode_chg) begin
      div_cnt_q <= 3'h0;
      gate_q <= 1'b0;
      dly_q <= 1'b0;
    end else begin
      dly_q <= dly_out;
      if (osc_rise) div_cnt_q <= div_wrap ? 3'h0 : div_cnt_q + 3'h1;
      if (osc_rise) gate_q <= 1'b0;
      else if (dat_rise && is_gate) gate_q <= 1'b1;
    end
  end
  // ****************************************
  // Phase frequency detector and lock detect
  // ****************************************
  logic [15:0] good_q;
  wire both = cmp_ref && cmp_osc;
  always_ff @(posedge sys_clk) begin
    if (srst || mode_chg) begin
      pump_up <= 1'b0;
      pump_down <= 1'b0;
    end else if (both || (pump_up && cmp_osc) || (pump_down && cmp_ref)) begin
      pump_up <= 1'b0;
      pump_down <= 1'b0;
    end else if (cmp_ref) begin
      pump_up <= 1'b1;
    end else if (cmp_osc) begin
      pump_down <= 1'b1;
    end
  end
  // Lock is declared after a count of comparisons ending in a tie or in the
  // closing edge after an error of any length; the count is software tunable.
  wire small_err = both || (cmp_osc && pump_up) || (cmp_ref && pump_down);
  wire judged = cmp_ref || cmp_osc;
  always_ff @(posedge sys_clk) begin
    if (srst || mode_chg) begin
      good_q <= 16'h0;
      locked_q <= 1'b0;
    end else if (is_acq && judged && !(pump_up || pump_down) && !both) begin
      good_q <= good_q;
    end else if (is_acq && small_err) begin
      good_q <= good_q + 16'h1;
      if (good_q + 16'h1 >= lock_q[15:0]) locked_q <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_q <= pll_ctl_pkg::mode_ref;
      cmp_cnt_q <= 32'h0;
      acq_mode <= 1'b0;
      gated_mode <= 1'b0;
    end else begin
      mode_q <= mode_d;
      acq_mode <= (mode_d == pll_ctl_pkg::mode_acq);
      gated_mode <= (mode_d == pll_ctl_pkg::mode_gate);
      if (both) cmp_cnt_q <= cmp_cnt_q + 32'h1;
    end
  end
  // ****************************************
  // Window data output buffer
  // ****************************************
  // Each oscillator edge in gated mode with fifo_en set closes one window unless a finished byte still waits on a full FIFO; the shifter packs the
  // data seen in each window into bytes for the FIFO.
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic hit_q;
  logic push_q;
  logic [7:0] push_data_q;
  logic f_in_ready;
  logic f_valid;
  logic [7:0] f_data;
  wire win_end = is_gate && osc_rise;
  always_ff @(posedge sys_clk) begin
    if (srst || mode_chg) begin
      shift_q <= 8'h0;
      bit_q <= 3'h0;
      hit_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= 8'h0;
    end else begin
      if (push_q && f_in_ready) push_q <= 1'b0;
      if (dat_rise) hit_q <= 1'b1;
      if (win_end && fifo_en && !(push_q && !f_in_ready)) begin
        shift_q <= {shift_q[6:0], hit_q || dat_rise};
        hit_q <= 1'b0;
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          push_q <= 1'b1;
          push_data_q <= {shift_q[6:0], hit_q || dat_rise};
        end
      end
    end
  end
  pll_fifo #(
    .width(pll_ctl_pkg::fifo_width),
    .depth(pll_ctl_pkg::fifo_depth)
  ) u_fifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(push_q),
    .in_ready(f_in_ready),
    .in_data(push_data_q),
    .out_valid(f_valid),
    .out_ready(!win_valid || win_ready),
    .out_data(f_data)
  );
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      win_valid <= 1'b0;
      win_data <= 8'h0;
    end else if (!win_valid || win_ready) begin
      win_valid <= f_valid;
      win_data <= f_data;
    end
  end
endmodule : pll_phase_ctl

// ==== pll_phase_ctl_props.sv ====
`timescale 1ns/1ps
module pll_phase_ctl_props (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic read_data,
  input wire logic read_gate,
  input wire logic pump_up,
  input wire logic pump_down,
  input wire logic acq_mode,
  input wire logic gated_mode,
  input wire logic [7:0] win_data,
  input wire logic win_valid,
  input wire logic win_ready
);
  // Saturates so that a long silence never wraps into a false alarm.
  logic [5:0] quiet_q;
  logic data_q;
  always_ff @(posedge sys_clk) begin
    data_q <= read_data;
    if (srst || (read_data && !data_q)) quiet_q <= 6'h00;
    else if (quiet_q != 6'h3f) quiet_q <= quiet_q + 6'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ****************************************
  // Checks
  // ****************************************
  chk_pump_exclusive: assert property (!(pump_up && pump_down))
    else $error("pump up and down high together");
  chk_reset_clear: assert property ($fell(srst) |->
    !(pump_up || pump_down || acq_mode || gated_mode))
    else $error("outputs not clear after reset");
  chk_mode_single: assert property (!(acq_mode && gated_mode))
    else $error("two modes at once");
  chk_gate_rise: assert property ($rose(read_gate) |->
    ##[1:4] (acq_mode || gated_mode))
    else $error("read gate rise left reference mode standing");
  chk_gate_fall: assert property ($fell(read_gate) |->
    ##[1:4] !(acq_mode || gated_mode))
    else $error("read gate fall did not return to reference");
  chk_mode_clear: assert property (($changed(acq_mode) ||
    $changed(gated_mode)) |-> ##[0:1] !(pump_up || pump_down))
    else $error("pump held across mode change");
  chk_quiet_hold: assert property (gated_mode && quiet_q > 6'h20 |->
    !(pump_up || pump_down))
    else $error("pump without data bit");
  chk_up_cause: assert property ($rose(pump_up) && gated_mode |->
    quiet_q < 6'h10)
    else $error("pump up far from any data bit");
  chk_win_hold: assert property (win_valid && !win_ready |=>
    win_valid && $stable(win_data))
    else $error("window byte dropped while stalled");
  cover property ($rose(gated_mode));
  cover property ($rose(acq_mode));
  cover property ($rose(pump_down) && gated_mode);
endmodule : pll_phase_ctl_props
bind pll_phase_ctl pll_phase_ctl_props chk_i (
  .sys_clk(sys_clk), .srst(srst), .read_data(read_data),
  .read_gate(read_gate), .pump_up(pump_up), .pump_down(pump_down),
  .acq_mode(acq_mode), .gated_mode(gated_mode), .win_data(win_data),
  .win_valid(win_valid), .win_ready(win_ready));

// ==== disk_side_model.sv ====
`timescale 1ns/1ps
module disk_side_model (
  input wire logic sys_clk,
  input wire logic gate_req,
  input wire logic pulse_req,
  output logic read_gate,
  output logic read_data
);
  logic gate_q = 1'b0;
  logic [1:0] width_q = 2'h0;
  // The bench asks for the gate only where a preamble starts.
  always_ff @(posedge sys_clk) begin
    gate_q <= gate_req;
  end
  // One request gives one rising edge; the level lasts two cycles.
  always_ff @(posedge sys_clk) begin
    if (pulse_req) width_q <= 2'h2;
    else if (width_q != 2'h0) width_q <= width_q - 2'h1;
  end
  assign read_gate = gate_q;
  assign read_data = (width_q != 2'h0);
endmodule : disk_side_model

// ==== disk_data_pll_phase_control_tb.sv ====
`timescale 1ns/1ps
module disk_data_pll_phase_control_tb;
  logic sys_clk = 1'b0, srst = 1'b1, ref_clk = 1'b0, osc = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, pump_up, pump_down, acq_mode, gated_mode;
  logic [7:0] win_data;
  logic win_valid, read_gate, read_data;
  logic win_ready = 1'b0, gate_req = 1'b0, pulse_req = 1'b0;
  int err_count = 0, samples_checked = 0, cycles = 0;
  int osc_half = 6, osc_cnt = 0, ref_half = 2;
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles % ref_half == 0) ref_clk <= ~ref_clk;
    osc_cnt <= (osc_cnt + 1 >= osc_half) ? 0 : osc_cnt + 1;
    if (osc_cnt + 1 >= osc_half) osc <= ~osc;
    if (cycles == 8000) begin
      err_count++;
      close_out();
    end
  end
  pll_phase_ctl dut (.sys_clk(sys_clk), .srst(srst),
    .double_rate_reference_clock(ref_clk), .oscillator_frequency(osc),
    .read_data(read_data), .read_gate(read_gate), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pump_up(pump_up), .pump_down(pump_down), .acq_mode(acq_mode),
    .gated_mode(gated_mode), .win_data(win_data), .win_valid(win_valid),
    .win_ready(win_ready));
  disk_side_model far_i (.sys_clk(sys_clk), .gate_req(gate_req),
    .pulse_req(pulse_req), .read_gate(read_gate), .read_data(read_data));
  task automatic close_out();
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic watch(input int n, output int up, output int dn);
    up = 0;
    dn = 0;
    repeat (n) begin
      @(posedge sys_clk);
      up += (pump_up === 1'b1);
      dn += (pump_down === 1'b1);
    end
  endtask : watch
  task automatic pulse(input int k);
    @(posedge osc);
    repeat (k) @(posedge sys_clk);
    pulse_req <= 1'b1;
    @(posedge sys_clk);
    pulse_req <= 1'b0;
  endtask : pulse
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    apb(1'b0, pll_ctl_pkg::ctrl_addr, 32'h0);
    check("ctrl", pll_ctl_pkg::ctrl_reset, rd);
    apb(1'b0, pll_ctl_pkg::lock_addr, 32'h0);
    check("lock", pll_ctl_pkg::lock_reset, rd);
    apb(1'b0, pll_ctl_pkg::stat_addr, 32'h0);
    check("mode", 32'h0, rd & 32'h7);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", 32'h1, {31'h0, er});
  endtask : t_reset
  task automatic t_ref();
    int up, dn;
    watch(80, up, dn);
    check("slow osc", 32'h1, 32'(up > 0 && dn == 0));
    osc_half = 3;
    watch(16, up, dn);
    watch(80, up, dn);
    check("fast osc", 32'h1, 32'(dn > 0 && up == 0));
  endtask : t_ref
  task automatic t_gated();
    int up, dn;
    ref_half = 1;
    osc_half = 6;
    apb(1'b1, pll_ctl_pkg::ctrl_addr, 32'h01);
    gate_req <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check("gated", 32'h1, {31'h0, gated_mode});
    watch(60, up, dn);
    check("no data", 32'h0, 32'(up + dn));
    pulse(0);
    watch(24, up, dn);
    check("early bit", 32'h1, 32'(up > 0 && dn == 0));
    pulse(10);
    watch(24, up, dn);
    check("late bit", 32'h1, 32'(dn > 0 && up == 0));
    watch(40, up, dn);
    check("gate shut", 32'h0, 32'(up + dn));
    gate_req <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check("to ref", 32'h0, {30'h0, acq_mode, gated_mode});
  endtask : t_gated
  task automatic t_codes();
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, pll_ctl_pkg::ctrl_addr, 32'(32'h10 | c));
      apb(1'b0, pll_ctl_pkg::ctrl_addr, 32'h0);
      check("code", 32'(32'h10 | c), rd & 32'h3f);
      gate_req <= 1'b1;
      repeat (6) @(posedge sys_clk);
      check("acq", 32'h1, {31'h0, acq_mode});
      gate_req <= 1'b0;
      repeat (6) @(posedge sys_clk);
      check("ref", 32'h0, {30'h0, acq_mode, gated_mode});
    end
  endtask : t_codes
  task automatic t_lock();
    int n;
    apb(1'b1, pll_ctl_pkg::lock_addr, 32'h4);
    apb(1'b1, pll_ctl_pkg::ctrl_addr, 32'h11);
    gate_req <= 1'b1;
    n = 0;
    while (gated_mode !== 1'b1 && n < 40) begin
      @(posedge osc);
      pulse(0);
      n++;
    end
    check("locked", 32'h1, {31'h0, gated_mode});
    check("lock count", 32'h1, 32'(n >= 4));
    gate_req <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask : t_lock
  task automatic t_fifo();
    int n;
    logic [7:0] last;
    apb(1'b1, pll_ctl_pkg::ctrl_addr, 32'h21);
    gate_req <= 1'b1;
    repeat (90) pulse(0);
    gate_req <= 1'b0;
    repeat (6) @(posedge sys_clk);
    win_ready <= 1'b1;
    n = 0;
    repeat (30) begin
      @(posedge sys_clk);
      if (win_valid === 1'b1) begin
        n++;
        last = win_data;
      end
    end
    win_ready <= 1'b0;
    check("depth", 32'h1, 32'(n >= 8 && n <= 9));
    check("window byte", 32'hff, {24'h0, last});
    check("empty", 32'h0, {31'h0, win_valid});
  endtask : t_fifo
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_ref();
    t_gated();
    t_codes();
    t_lock();
    t_fifo();
    close_out();
  end
endmodule : disk_data_pll_phase_control_tb
